// ---- rtl/cscr_regs.vh ----
/*
 * Register map, field positions, reset values and bus constants of the
 * charger status and control register slice.
 * Assumes: included by bare name from the design files of this slice.
 */
`ifndef CSCR_REGS_VH
`define CSCR_REGS_VH

// ==========================================================
// register offsets (8-bit register pointer)
`define CSCR_OFS_MONITOR_B      8'h11
`define CSCR_OFS_THERMISTOR     8'h12
`define CSCR_OFS_WATCHDOG_REGULATOR_CONTROL     8'h13
`define CSCR_OFS_RESTART_KEY    8'hFA

// ==========================================================
// charger_monitor_b fields
`define CSCR_MON_POWER_GOOD     5
`define CSCR_MON_DISABLE_LEVEL  4
`define CSCR_MON_BATT_ABSENT    3
`define CSCR_MON_POST_CHARGE    2

// ==========================================================
// thermistor_status fields
`define CSCR_THM_OVERRIDE       5
`define CSCR_THM_SENSE_VALID    4
`define CSCR_THM_ABOVE_T4       3
`define CSCR_THM_ABOVE_T3       2
`define CSCR_THM_ABOVE_T2       1
`define CSCR_THM_ABOVE_T1       0
`define CSCR_THM_OVERRIDE_RST   1'b0

// ==========================================================
// watchdog_regulator_control fields and values
`define CSCR_WD_REG_ENABLE      2
`define CSCR_WD_DISABLE         1
`define CSCR_WD_RESET_VALUE     8'h6E
`define CSCR_WD_FIXED_ONES      8'h68
`define CSCR_WD_REG_ENABLE_RST  1'b1
`define CSCR_WD_DISABLE_RST     1'b1

// ==========================================================
// charge_restart_key values
`define CSCR_RESTART_READ       8'hFF
`define CSCR_RESTART_KEY        8'hB5

// ==========================================================
// serial bus constants
`define CSCR_DEVICE_ADDR        7'h5A
`define CSCR_READ_UNMAPPED      8'h00

`endif

// ---- rtl/cscr_sync.v ----
/*
 * Two-stage synchroniser for a vector of asynchronous levels.
 * Assumes: every bit is a level that is independent of its neighbours;
 * words that must stay coherent across bits are not passed through here.
 */
`timescale 1ns/1ps
module cscr_sync #(
    parameter             WIDTH   = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    // clock and reset
    input  wire             clock,
    input  wire             rst_n,
    // levels in and out
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout_q
);

    reg [WIDTH-1:0] meta_q;

    // ==========================================================
    // synchroniser stages
    // first stage feeds only the second stage
    always @(posedge clock) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            dout_q <= RST_VAL;
        end else begin
            meta_q <= din;
            dout_q <= meta_q;
        end
    end

endmodule // cscr_sync

// ---- rtl/cscr_top.v ----
/*
 * Charger status and control register slice behind an oversampled
 * serial two-wire slave port, with the power-good open-drain pin.
 * Assumes: pins and analog status levels are asynchronous to clock;
 * the serial clock is far slower than clock (at least 8 clocks per phase).
 */
`timescale 1ns/1ps
`include "cscr_regs.vh"
module cscr_top #(
    parameter [6:0] DEVICE_ADDR = `CSCR_DEVICE_ADDR
) (
    // clock and reset
    input  wire clock,
    input  wire rst_n,
    // serial bus pins
    input  wire scl_in,
    input  wire sda_in,
    output reg  sda_out_q,
    output reg  sda_oe_q,
    // status levels from the charger
    input  wire low_battery_threshold,
    input  wire disable_pin,
    input  wire battery_absent,
    input  wire post_charge_active,
    input  wire thermistor_sense_valid,
    input  wire thermistor_above_t4,
    input  wire thermistor_above_t3,
    input  wire thermistor_above_t2,
    input  wire thermistor_above_t1,
    input  wire charge_done,
    // power-good open-drain pin
    output reg  power_good_out_q,
    output reg  power_good_oe_q,
    // controls to the charger
    output reg  thermistor_override_q,
    output reg  regulator_enable_bit_q,
    output reg  watchdog_disable_q,
    output reg  charge_restart_q
);

    // ==========================================================
    // states
    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_ADDR  = 3'd1;
    localparam [2:0] ST_ACK_A = 3'd2;
    localparam [2:0] ST_WR    = 3'd3;
    localparam [2:0] ST_ACK_W = 3'd4;
    localparam [2:0] ST_RD    = 3'd5;
    localparam [2:0] ST_MACK  = 3'd6;

    localparam       SYNC_W   = 12;

    // ==========================================================
    // declarations
    wire [SYNC_W-1:0] sync_s;
    wire              scl_s;
    wire              sda_s;
    wire              low_batt_s;
    wire              dis_s;
    wire              absent_s;
    wire              post_s;
    wire              valid_s;
    wire [3:0]        above_s;
    wire              done_s;
    wire              scl_rise;
    wire              scl_fall;
    wire              bus_start;
    wire              bus_stop;

    reg               scl_p_q;
    reg               sda_p_q;
    reg  [2:0]        state_q;
    reg  [2:0]        bitcnt_q;
    reg  [7:0]        shift_q;
    reg  [7:0]        ptr_q;
    reg               byte_done_q;
    reg               rw_q;
    reg               first_q;
    reg               nack_q;
    reg               power_good_flag_q;
    reg  [7:0]        rd_data;

    // ==========================================================
    // pin and status synchronisers
    // bus lines reset high so no false start is seen at release
    cscr_sync #(
        .WIDTH   (SYNC_W),
        .RST_VAL (12'h003)
    ) u_sync (
        .clock  (clock),
        .rst_n  (rst_n),
        .din    ({charge_done, thermistor_above_t4, thermistor_above_t3,
                  thermistor_above_t2, thermistor_above_t1,
                  thermistor_sense_valid, post_charge_active,
                  battery_absent, disable_pin, low_battery_threshold,
                  sda_in, scl_in}),
        .dout_q (sync_s)
    );

    assign scl_s      = sync_s[0];
    assign sda_s      = sync_s[1];
    assign low_batt_s = sync_s[2];
    assign dis_s      = sync_s[3];
    assign absent_s   = sync_s[4];
    assign post_s     = sync_s[5];
    assign valid_s    = sync_s[6];
    assign above_s    = sync_s[10:7];
    assign done_s     = sync_s[11];

    // ==========================================================
    // bus line events
    assign scl_rise  = scl_s & ~scl_p_q;
    assign scl_fall  = ~scl_s & scl_p_q;
    assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // ==========================================================
    // read data multiplexer
    always @* begin
        rd_data = `CSCR_READ_UNMAPPED;
        if (ptr_q == `CSCR_OFS_MONITOR_B) begin
            rd_data = 8'h00;
            rd_data[`CSCR_MON_POWER_GOOD]    = power_good_flag_q;
            rd_data[`CSCR_MON_DISABLE_LEVEL] = dis_s;
            rd_data[`CSCR_MON_BATT_ABSENT]   = absent_s;
            rd_data[`CSCR_MON_POST_CHARGE]   = post_s;
        end else if (ptr_q == `CSCR_OFS_THERMISTOR) begin
            rd_data = 8'h00;
            rd_data[`CSCR_THM_OVERRIDE]    = thermistor_override_q;
            rd_data[`CSCR_THM_SENSE_VALID] = valid_s;
            rd_data[`CSCR_THM_ABOVE_T4]    = above_s[3];
            rd_data[`CSCR_THM_ABOVE_T3]    = above_s[2];
            rd_data[`CSCR_THM_ABOVE_T2]    = above_s[1];
            rd_data[`CSCR_THM_ABOVE_T1]    = above_s[0];
        end else if (ptr_q == `CSCR_OFS_WATCHDOG_REGULATOR_CONTROL) begin
            rd_data = `CSCR_WD_FIXED_ONES;
            rd_data[`CSCR_WD_REG_ENABLE] = regulator_enable_bit_q;
            rd_data[`CSCR_WD_DISABLE]    = watchdog_disable_q;
        end else if (ptr_q == `CSCR_OFS_RESTART_KEY) begin
            rd_data = `CSCR_RESTART_READ;
        end
    end

    // ==========================================================
    // power-good pin and its mirror bit
    // flag and pin enable update on the same edge so they agree out of reset; reset clears both, releasing the pin while the flag reads 0
    always @(posedge clock) begin
        if (!rst_n) begin
            power_good_flag_q <= 1'b0;
            power_good_out_q  <= 1'b0;
            power_good_oe_q   <= 1'b0;
        end else begin
            power_good_flag_q <= low_batt_s;
            power_good_out_q  <= 1'b0;
            power_good_oe_q   <= ~low_batt_s;
        end
    end

    // ==========================================================
    // serial slave and register writes
    always @(posedge clock) begin
        if (!rst_n) begin
            scl_p_q                <= 1'b1;
            sda_p_q                <= 1'b1;
            state_q                <= ST_IDLE;
            bitcnt_q               <= 3'd0;
            shift_q                <= 8'h00;
            ptr_q                  <= 8'h00;
            byte_done_q            <= 1'b0;
            rw_q                   <= 1'b0;
            first_q                <= 1'b0;
            nack_q                 <= 1'b0;
            sda_out_q              <= 1'b0;
            sda_oe_q               <= 1'b0;
            thermistor_override_q  <= `CSCR_THM_OVERRIDE_RST;
            regulator_enable_bit_q <= `CSCR_WD_REG_ENABLE_RST;
            watchdog_disable_q     <= `CSCR_WD_DISABLE_RST;
            charge_restart_q       <= 1'b0;
        end else begin
            scl_p_q          <= scl_s;
            sda_p_q          <= sda_s;
            sda_out_q        <= 1'b0;
            charge_restart_q <= 1'b0;
            if (bus_start) begin
                // also a repeated start; the pointer is kept
                state_q     <= ST_ADDR;
                bitcnt_q    <= 3'd0;
                byte_done_q <= 1'b0;
                sda_oe_q    <= 1'b0;
            end else if (bus_stop) begin
                state_q  <= ST_IDLE;
                sda_oe_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_ADDR, ST_WR: begin
                        if (scl_rise) begin
                            shift_q  <= {shift_q[6:0], sda_s};
                            bitcnt_q <= bitcnt_q + 3'd1;
                            if (bitcnt_q == 3'd7) begin
                                byte_done_q <= 1'b1;
                            end
                        end else if (scl_fall && byte_done_q) begin
                            byte_done_q <= 1'b0;
                            if (state_q == ST_ADDR) begin
                                if (shift_q[7:1] == DEVICE_ADDR) begin
                                    rw_q     <= shift_q[0];
                                    sda_oe_q <= 1'b1;
                                    state_q  <= ST_ACK_A;
                                end else begin
                                    state_q <= ST_IDLE;
                                end
                            end else begin
                                sda_oe_q <= 1'b1;
                                state_q  <= ST_ACK_W;
                                if (first_q) begin
                                    ptr_q   <= shift_q;
                                    first_q <= 1'b0;
                                end else begin
                                    ptr_q <= ptr_q + 8'h01;
                                    if (ptr_q == `CSCR_OFS_THERMISTOR) begin
                                        thermistor_override_q <=
                                            shift_q[`CSCR_THM_OVERRIDE];
                                    end else if (ptr_q == `CSCR_OFS_WATCHDOG_REGULATOR_CONTROL) begin
                                        regulator_enable_bit_q <=
                                            shift_q[`CSCR_WD_REG_ENABLE];
                                        watchdog_disable_q <=
                                            shift_q[`CSCR_WD_DISABLE];
                                    end else if (ptr_q == `CSCR_OFS_RESTART_KEY) begin
                                        // key outside charge done is ignored
                                        if ((shift_q == `CSCR_RESTART_KEY) && done_s) begin
                                            charge_restart_q <= 1'b1;
                                        end
                                    end
                                end
                            end
                        end
                    end
                    ST_ACK_A: begin
                        if (scl_fall) begin
                            bitcnt_q <= 3'd0;
                            if (rw_q) begin
                                shift_q  <= rd_data;
                                ptr_q    <= ptr_q + 8'h01;
                                sda_oe_q <= ~rd_data[7];
                                state_q  <= ST_RD;
                            end else begin
                                sda_oe_q <= 1'b0;
                                first_q  <= 1'b1;
                                state_q  <= ST_WR;
                            end
                        end
                    end
                    ST_ACK_W: begin
                        if (scl_fall) begin
                            sda_oe_q <= 1'b0;
                            state_q  <= ST_WR;
                        end
                    end
                    ST_RD: begin
                        if (scl_fall) begin
                            bitcnt_q <= bitcnt_q + 3'd1;
                            if (bitcnt_q == 3'd7) begin
                                sda_oe_q <= 1'b0;
                                state_q  <= ST_MACK;
                            end else begin
                                shift_q  <= {shift_q[6:0], 1'b0};
                                sda_oe_q <= ~shift_q[6];
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            nack_q <= sda_s;
                        end else if (scl_fall) begin
                            if (nack_q) begin
                                state_q <= ST_IDLE;
                            end else begin
                                bitcnt_q <= 3'd0;
                                shift_q  <= rd_data;
                                ptr_q    <= ptr_q + 8'h01;
                                sda_oe_q <= ~rd_data[7];
                                state_q  <= ST_RD;
                            end
                        end
                    end
                    default: begin
                        sda_oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule // cscr_top

// ---- dv/cscr_assertions.sv ----
/* port assertions for the charger status and control register slice
   assumes: bound onto cscr_top; one clock, synchronous active-low reset */
`timescale 1ns/1ps
module cscr_assertions (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // serial pins
    input wire scl_in,
    input wire sda_out_q,
    input wire sda_oe_q,
    // status levels
    input wire low_battery_threshold,
    input wire charge_done,
    // outputs
    input wire power_good_out_q,
    input wire power_good_oe_q,
    input wire thermistor_override_q,
    input wire regulator_enable_bit_q,
    input wire watchdog_disable_q,
    input wire charge_restart_q
);
    // ====
    // helper counters: both levels pass a sync stage, so allow settling
    logic [2:0] lb_cnt_q;
    logic [2:0] done_age_q;
    logic       lb_last_q;
    always @(posedge clock) begin
        lb_last_q <= low_battery_threshold;
        if (!rst_n || lb_last_q != low_battery_threshold) lb_cnt_q <= 3'h0;
        else if (lb_cnt_q != 3'h7) lb_cnt_q <= lb_cnt_q + 3'h1;
        if (!rst_n || charge_done) done_age_q <= 3'h0;
        else if (done_age_q != 3'h7) done_age_q <= done_age_q + 3'h1;
    end
    // ====
    // properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_drive_begins; $rose(sda_oe_q); endsequence
    sequence s_drive_holds; sda_oe_q [*4]; endsequence
    a_pg_pin_low: assert property (power_good_out_q == 1'b0)
        else $error("power-good pin value not low");
    a_pg_follows_batt: assert property (
        (lb_cnt_q >= 3'h4 && low_battery_threshold == lb_last_q) |->
        power_good_oe_q == !low_battery_threshold) else $error("power-good drive wrong");
    a_reset_defaults: assert property (disable iff (1'b0) !rst_n |=>
        (regulator_enable_bit_q && watchdog_disable_q && !thermistor_override_q &&
        !charge_restart_q && !sda_oe_q && !power_good_oe_q)) else $error("reset values wrong");
    a_restart_single: assert property (charge_restart_q |=> !charge_restart_q)
        else $error("restart pulse longer than one cycle");
    a_restart_gated: assert property (charge_restart_q |-> done_age_q <= 3'h4)
        else $error("restart without charge done");
    a_ctrl_idle_stable: assert property (scl_in [*8] |-> !charge_restart_q &&
        $stable({thermistor_override_q, regulator_enable_bit_q, watchdog_disable_q}))
        else $error("control changed while bus clock high");
    a_ack_stands: assert property (s_drive_begins |=> s_drive_holds)
        else $error("data drive too short");
    a_sda_moves_low: assert property ($changed(sda_oe_q) |-> !scl_in)
        else $error("data drive changed while bus clock high");
    a_sda_value_low: assert property (sda_out_q == 1'b0)
        else $error("data pin value not low");
endmodule // cscr_assertions

// ---- dv/cscr_host_model.sv ----
/* host controller model for the two-wire register port
   assumes: the bench resolves the data line with a pull-up */
`timescale 1ns/1ps
module cscr_host_model (
    // clock
    input  wire        clock,
    // bus pins
    output logic       scl,
    output logic       sda_pull,
    input  wire        sda_line,
    // last byte read
    output logic [7:0] rd_byte
);
    event rd_ev;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        rd_byte = 8'h00;
    end
    // ====
    // ten-clock phases, two clocks above the eight-clock minimum
    task automatic phase();
        repeat (10) @(negedge clock);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_pull = !b;
        phase();
        scl = 1'b1;
        phase();
        r = sda_line;
        scl = 1'b0;
        phase();
    endtask
    task automatic start();
        sda_pull = 1'b0;
        phase();
        scl = 1'b1;
        phase();
        sda_pull = 1'b1;
        phase();
        scl = 1'b0;
        phase();
    endtask
    task automatic stop();
        sda_pull = 1'b1;
        phase();
        scl = 1'b1;
        phase();
        sda_pull = 1'b0;
        phase();
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, ack);
    endtask
    task automatic rbyte(input logic last);
        logic [7:0] d;
        logic       r;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, r);
            d = {d[6:0], r};
        end
        bit_io(last, r);
        rd_byte = d;
        -> rd_ev;
    endtask
endmodule // cscr_host_model

// ---- dv/testbench.sv ----
/* self-checking bench for the charger status and control register slice
   assumes: design, host model and checker compiled before this file */
`timescale 1ns/1ps
`include "cscr_regs.vh"
module testbench;
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic [9:0] stat = 10'h000; // lowbat dis absent post valid t4 t3 t2 t1 done
    logic [7:0] seed = 8'h0D;
    logic [7:0] exp_q[$];
    logic [7:0] wdv[4] = '{8'h00, 8'hFF, 8'h02, 8'h04};
    logic       ack;
    logic       ovr_exp = 1'b0;
    integer     mismatches = 0;
    integer     checked = 0;
    integer     pulses = 0;
    wire        scl, sda_pull, sda_out_q, sda_oe_q, pg_out, pg_oe, ovr, reg_en, watchdog_disable, restart;
    wire [7:0]  rd_byte;
    wire        sda_line = (sda_pull || (sda_oe_q && !sda_out_q)) ? 1'b0 : 1'b1;
    always #4 clock = ~clock;
    always @(posedge clock) if (restart === 1'b1) pulses++;
    cscr_top dut (.clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .low_battery_threshold(stat[9]),
        .disable_pin(stat[8]), .battery_absent(stat[7]), .post_charge_active(stat[6]),
        .thermistor_sense_valid(stat[5]), .thermistor_above_t4(stat[4]),
        .thermistor_above_t3(stat[3]), .thermistor_above_t2(stat[2]),
        .thermistor_above_t1(stat[1]), .charge_done(stat[0]), .power_good_out_q(pg_out),
        .power_good_oe_q(pg_oe), .thermistor_override_q(ovr), .regulator_enable_bit_q(reg_en),
        .watchdog_disable_q(watchdog_disable), .charge_restart_q(restart));
    cscr_host_model host (.clock(clock), .scl(scl), .sda_pull(sda_pull), .sda_line(sda_line),
        .rd_byte(rd_byte));
    // ====
    // helpers
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic set_stat(input logic [9:0] v);
        @(negedge clock);
        stat = v;
        repeat (8) @(negedge clock);
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        host.start();
        host.wbyte({`CSCR_DEVICE_ADDR, 1'b0}, ack);
        chk("address ack", {7'h00, ack}, 8'h00);
        host.wbyte(ofs, ack);
        host.wbyte(d, ack);
        host.stop();
    endtask
    task automatic rd(input logic [7:0] ofs, input int n);
        host.start();
        host.wbyte({`CSCR_DEVICE_ADDR, 1'b0}, ack);
        host.wbyte(ofs, ack);
        host.start();
        host.wbyte({`CSCR_DEVICE_ADDR, 1'b1}, ack);
        for (int i = 0; i < n; i++) host.rbyte(i == n - 1);
        host.stop();
    endtask
    // ====
    // read monitor: each byte read is matched to the oldest note
    always @(host.rd_ev) chk("read byte", host.rd_byte, exp_q.size() ? exp_q.pop_front() : 8'hxx);
    initial begin
        repeat (100000) @(posedge clock);
        mismatches++;
        $display("[FAIL] run length expected finish seen timeout");
        test_done();
    end
    // ====
    // main sequence
    initial begin
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        repeat (5) @(negedge clock);
        chk("regulator enable", {7'h00, reg_en}, 8'h01);
        chk("watchdog disable", {7'h00, watchdog_disable}, 8'h01);
        chk("override", {7'h00, ovr}, 8'h00);
        exp_q.push_back(`CSCR_WD_RESET_VALUE);
        exp_q.push_back(`CSCR_READ_UNMAPPED);
        rd(`CSCR_OFS_WATCHDOG_REGULATOR_CONTROL, 2);
        exp_q.push_back(8'hFF);
        rd(`CSCR_OFS_RESTART_KEY, 1);
        // a foreign address must be left unanswered
        host.start();
        host.wbyte({`CSCR_DEVICE_ADDR ^ 7'h01, 1'b0}, ack);
        host.stop();
        chk("foreign address ack", {7'h00, ack}, 8'h01);
        $display("reset values test done");
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            set_stat({seed, seed[3] ^ seed[6], 1'b0});
            chk("power-good drive", {7'h00, pg_oe}, {7'h00, !stat[9]});
            exp_q.push_back({2'b00, stat[9:6], 2'b00});
            exp_q.push_back({2'b00, ovr_exp, stat[5:1]});
            rd(`CSCR_OFS_MONITOR_B, 2);
            if (k == 2) begin
                wr(`CSCR_OFS_THERMISTOR, 8'hFF);
                wr(`CSCR_OFS_MONITOR_B, 8'hFF);
                ovr_exp = 1'b1;
                chk("override", {7'h00, ovr}, 8'h01);
            end
        end
        $display("status test done");
        foreach (wdv[i]) begin
            wr(`CSCR_OFS_WATCHDOG_REGULATOR_CONTROL, wdv[i]);
            chk("regulator enable", {7'h00, reg_en}, {7'h00, wdv[i][2]});
            chk("watchdog disable", {7'h00, watchdog_disable}, {7'h00, wdv[i][1]});
            exp_q.push_back(8'h68 | (wdv[i] & 8'h06));
            rd(`CSCR_OFS_WATCHDOG_REGULATOR_CONTROL, 1);
        end
        $display("watchdog control test done");
        for (int j = 0; j < 3; j++) begin
            set_stat({stat[9:1], j != 0});
            pulses = 0;
            wr(`CSCR_OFS_RESTART_KEY, j == 1 ? 8'hB4 : `CSCR_RESTART_KEY);
            chk("restart pulses", pulses[7:0], {7'h00, j == 2});
        end
        $display("restart test done");
        test_done();
    end
endmodule // testbench
bind cscr_top cscr_assertions u_chk (.clock(clock), .rst_n(rst_n), .scl_in(scl_in),
    .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .low_battery_threshold(low_battery_threshold),
    .charge_done(charge_done), .power_good_out_q(power_good_out_q),
    .power_good_oe_q(power_good_oe_q), .thermistor_override_q(thermistor_override_q),
    .regulator_enable_bit_q(regulator_enable_bit_q), .watchdog_disable_q(watchdog_disable_q),
    .charge_restart_q(charge_restart_q));
